// >>> rcd_cfg.svh
// rcd_cfg.svh: timing counts and reset values of the reset/init sequencer
// assumes a single 50 MHz core clock; included by bare name
`ifndef RCD_CFG_SVH
`define RCD_CFG_SVH

// core clock period in picoseconds
`define RCD_CLK_PERIOD_PS   20000
// clock stabilization time, microseconds
`define RCD_STAB_US         15
// stabilization time rounds down to whole cycles, with no lower bound here
`define RCD_STAB_CYCLES     ((`RCD_STAB_US * 1000000) / `RCD_CLK_PERIOD_PS)
// default activation time in cycles (plain value, adjustable by parameter)
`define RCD_ACT_CYCLES      100
// controller reset holds, for reference only
`define RCD_PWRUP_HOLD_US   200
`define RCD_SOFT_HOLD_NS    100
// control word store layout
`define RCD_CW_AW           4
`define RCD_CW_DW           4
`define RCD_CW_RESET        4'h0
// control word 0, bit 0: float address/command while deselected
`define RCD_CW_FLOAT_ADDR   4'h0
`define RCD_CW_FLOAT_BIT    0

`endif

// >>> rcd_pkg.sv
// rcd_pkg.sv: types shared by the reset/init sequencer files
// assumes rcd_cfg.svh for the numeric constants
package rcd_pkg;

  // sequencer states, gray coded along reset -> settle -> run
  typedef enum logic [1:0] {
    RCD_ST_RESET  = 2'b00,
    RCD_ST_SETTLE = 2'b01,
    RCD_ST_RUN    = 2'b11
  } rcd_state_t;

endpackage : rcd_pkg

// >>> rcd_cw_if.sv
// rcd_cw_if.sv: carrier between the sequencer and its control word store
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`include "rcd_cfg.svh"

interface rcd_cw_if;
  logic                    we;
  logic [`RCD_CW_AW-1:0]   waddr;
  logic [`RCD_CW_DW-1:0]   wdata;
  logic [`RCD_CW_AW-1:0]   raddr;
  logic [`RCD_CW_DW-1:0]   rdata;

  modport user  (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : rcd_cw_if

// >>> rcd_cw_store.sv
// rcd_cw_store.sv: control word memory, cleared to defaults by reset
// assumes a single clock; read data comes from a register
`timescale 1ns/1ps
`include "rcd_cfg.svh"

module rcd_cw_store (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // access port
  rcd_cw_if.store   cw
);
  import rcd_pkg::*;

  localparam int DEPTH = 1 << `RCD_CW_AW;

  logic [`RCD_CW_DW-1:0] mem_q [DEPTH];
  logic [`RCD_CW_DW-1:0] mem_d [DEPTH];
  logic [`RCD_CW_DW-1:0] rdata_q;
  logic [`RCD_CW_DW-1:0] rdata_d;

  ////////////////////////////////////////////////////////////////////////
  // next values: one word written, read port registered
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (cw.we) begin
      mem_d[cw.waddr] = cw.wdata;
    end
    rdata_d = mem_q[cw.raddr];
  end

  // reset restores every word to its default
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= `RCD_CW_RESET;
      end
      rdata_q <= `RCD_CW_RESET;
    end else begin
      mem_q   <= mem_d;
      rdata_q <= rdata_d;
    end
  end

  assign cw.rdata = rdata_q;

endmodule : rcd_cw_store

// >>> rcd_reset_init_sequencer.sv
// rcd_reset_init_sequencer.sv: reset entry, release and first-edge output
// sequencing of a registering clock driver, plus plain registered pass-through
// assumes core_clk is the input clock and rst the reset, already synchronous
// to nothing: rst acts asynchronously, outputs released by the first edge
`timescale 1ns/1ps
`include "rcd_cfg.svh"

// Contract
// - in reset clock enables drive low, parity error output stays inactive high.
// - after release, before the first edge, termination outputs drive low.
// - after the first edge termination outputs follow their inputs.
// - after the release step outputs follow ordinary pass-through behaviour.
// - feedback clock may be driven or undriven during initialization.
// - a reset with stable clock follows the same entry and release sequence.
// - in reset every output floats except clock enables, held low.
// - in reset all control words return to their defaults.
module rcd_reset_init_sequencer #(
  parameter int AC_W        = 22,
  parameter int ACT_CYCLES  = `RCD_ACT_CYCLES,
  parameter int STAB_CYCLES = `RCD_STAB_CYCLES
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst,
  // mode strap: low selects four chip selects
  input  wire logic            four_select_mode,
  // controller side
  input  wire logic [3:0]      chip_select_in,
  input  wire logic [1:0]      clock_enable_in,
  input  wire logic [1:0]      termination_ctrl_in,
  input  wire logic [AC_W-1:0] addr_cmd_in,
  input  wire logic            parity_in,
  // dram side, chip selects
  output logic [3:0]           chip_select_out,
  output logic                 chip_select_out_oe,
  // dram side, clock enables (two copies, always driven)
  output logic [3:0]           clock_enable_out,
  // dram side, termination controls (two copies)
  output logic [3:0]           termination_ctrl_out,
  output logic                 termination_ctrl_out_oe,
  // dram side, address and command
  output logic [AC_W-1:0]      addr_cmd_out,
  output logic                 addr_cmd_out_oe,
  // open-drain error flag and feedback clock
  output logic                 parity_error_out,
  output logic                 parity_error_out_oe,
  output logic                 feedback_clock_out,
  output logic                 feedback_clock_out_oe,
  // sequencer status
  output logic                 init_done
);
  import rcd_pkg::*;

  // hold window for the chip selects: stabilization minus activation
  localparam int HOLD_RAW    = STAB_CYCLES - ACT_CYCLES;
  localparam int HOLD_CYCLES = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
  localparam int CNT_W       = $clog2(HOLD_CYCLES + 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);

  // true when every chip select in use is high
  function automatic logic all_deselected(input logic [3:0] cs, input logic quad_n);
    all_deselected = quad_n ? &cs[1:0] : &cs;
  endfunction : all_deselected

  // true when a control word access is requested
  function automatic logic cw_access(input logic [3:0] cs, input logic quad_n);
    cw_access = quad_n ? (cs[1:0] == 2'b00) : (cs == 4'h0);
  endfunction : cw_access

  ////////////////////////////////////////////////////////////////////////
  // sequencer state

  rcd_state_t              state_q;
  rcd_state_t              state_d;
  logic [CNT_W-1:0]        cnt_q;
  logic [CNT_W-1:0]        cnt_d;
  logic                    quad_n_q;
  logic                    quad_n_d;

  // reset -> settle at first edge, settle -> run once the hold expires
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    quad_n_d = quad_n_q;
    unique case (state_q)
      RCD_ST_RESET: begin
        // strap caught at the first edge after release
        quad_n_d = four_select_mode;
        cnt_d    = '0;
        state_d  = RCD_ST_SETTLE;
      end
      RCD_ST_SETTLE: begin
        if (cnt_q == HOLD_LAST) begin
          state_d = RCD_ST_RUN;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      RCD_ST_RUN: begin
        state_d = RCD_ST_RUN;
      end
      default: begin
        state_d = RCD_ST_RESET;
      end
    endcase
  end

  // a soft reset lands in the same state as power-up
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q  <= RCD_ST_RESET;
      cnt_q    <= '0;
      quad_n_q <= 1'b1;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      quad_n_q <= quad_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control word store

  rcd_cw_if cw ();

  logic cw_we;
  assign cw_we = (state_q == RCD_ST_RUN) && cw_access(chip_select_in, quad_n_q);

  // writes only once running; inputs are don't-care before that
  assign cw.we    = cw_we;
  assign cw.waddr = addr_cmd_in[`RCD_CW_AW-1:0];
  assign cw.wdata = addr_cmd_in[2*`RCD_CW_AW-1:`RCD_CW_AW];
  assign cw.raddr = `RCD_CW_FLOAT_ADDR;

  rcd_cw_store u_cw_store (
    .core_clk (core_clk),
    .rst      (rst),
    .cw       (cw.store)
  );

  logic float_en;
  assign float_en = cw.rdata[`RCD_CW_FLOAT_BIT];

  ////////////////////////////////////////////////////////////////////////
  // output registers

  logic [3:0]      cs_q;
  logic [3:0]      cs_d;
  logic [3:0]      cke_q;
  logic [3:0]      cke_d;
  logic [3:0]      odt_q;
  logic [3:0]      odt_d;
  logic [AC_W-1:0] ac_q;
  logic [AC_W-1:0] ac_d;
  logic            desel_q;
  logic            desel_d;
  logic            fb_q;
  logic            fb_d;

  // registered pass-through, gated by the sequencer state
  always_comb begin
    cs_d    = 4'hf;
    desel_d = 1'b1;
    // clock enables are plain copies; controller keeps them low while settling
    cke_d   = {clock_enable_in, clock_enable_in};
    // termination follows its input from the first edge on
    odt_d   = {termination_ctrl_in, termination_ctrl_in};
    ac_d    = addr_cmd_in;
    fb_d    = ~fb_q;
    if (state_q == RCD_ST_RUN) begin
      // a control word access is not forwarded to the drams
      if (!cw_access(chip_select_in, quad_n_q)) begin
        cs_d = chip_select_in;
      end
      if (quad_n_q) begin
        cs_d[3:2] = 2'b11; // unused selects stay deselected
      end
      desel_d = all_deselected(chip_select_in, quad_n_q);
    end
    // chip selects held high while settling, whatever the inputs show
    else begin
      cs_d = 4'hf;
    end
  end

  // reset values are what the pins show between release and first edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_q    <= 4'hf;
      cke_q   <= 4'h0;
      odt_q   <= 4'h0;
      ac_q    <= '0;
      desel_q <= 1'b1;
      fb_q    <= 1'b0;
    end else begin
      cs_q    <= cs_d;
      cke_q   <= cke_d;
      odt_q   <= odt_d;
      ac_q    <= ac_d;
      desel_q <= desel_d;
      fb_q    <= fb_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drive; enables follow rst directly so floating is immediate

  assign chip_select_out         = cs_q;
  assign chip_select_out_oe      = ~rst;
  assign clock_enable_out        = cke_q;
  assign termination_ctrl_out    = odt_q;
  assign termination_ctrl_out_oe = ~rst;
  assign addr_cmd_out            = ac_q;
  // float enable saves bus power; drive returns on the same edge as the reselecting command
  assign addr_cmd_out_oe         = ~rst & ~(float_en & desel_q);

  // parity checking lives elsewhere: the flag stays released (pulled high)
  assign parity_error_out        = 1'b0;
  assign parity_error_out_oe     = 1'b0;

  // feedback clock: undriven in reset, a core_clk/2 toggle afterwards
  assign feedback_clock_out      = fb_q;
  assign feedback_clock_out_oe   = ~rst;

  assign init_done               = (state_q == RCD_ST_RUN);

  // parity input is outside this block's scope
  logic unused_parity;
  assign unused_parity = parity_in;

endmodule : rcd_reset_init_sequencer

// >>> rcd_seq_checker.sv
// rcd_seq_checker.sv: port assertions of the reset/init sequencer
// assumes it is bound onto the sequencer top with the same counts
`timescale 1ns/1ps
module rcd_seq_checker #(
  parameter int ACT_CYCLES  = 5,
  parameter int STAB_CYCLES = 20
) (
  // clock, reset and status
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       init_done,
  // watched controller inputs
  input wire logic [1:0] clock_enable_in,
  input wire logic [1:0] termination_ctrl_in,
  // watched device outputs
  input wire logic [3:0] chip_select_out,
  input wire logic       chip_select_out_oe,
  input wire logic [3:0] clock_enable_out,
  input wire logic [3:0] termination_ctrl_out,
  input wire logic       termination_ctrl_out_oe,
  input wire logic       addr_cmd_out_oe,
  input wire logic       parity_error_out_oe,
  input wire logic       feedback_clock_out,
  input wire logic       feedback_clock_out_oe
);
  // settle length; reset checks run without a disable on purpose
  localparam int HOLD = STAB_CYCLES - ACT_CYCLES;
  default clocking cb @(posedge core_clk); endclocking
  ////////////////////////////////////////////////////////////////
  AST_RST_OUT: assert property (rst |-> clock_enable_out == 4'h0 && !parity_error_out_oe)
    else $error("reset output levels wrong");
  AST_RST_FLOAT: assert property (rst |-> !(chip_select_out_oe
    || termination_ctrl_out_oe || addr_cmd_out_oe || feedback_clock_out_oe))
    else $error("output driven in reset");
  AST_FIRST_EDGE: assert property ($fell(rst) |-> termination_ctrl_out == 4'h0
    && termination_ctrl_out_oe && chip_select_out == 4'hf && chip_select_out_oe)
    else $error("release state wrong");
  AST_ODT_FOLLOW: assert property (disable iff (rst) !$past(rst) |->
    termination_ctrl_out == {2{$past(termination_ctrl_in)}})
    else $error("termination output not following");
  AST_CKE_FOLLOW: assert property (disable iff (rst) !$past(rst) |->
    clock_enable_out == {2{$past(clock_enable_in)}})
    else $error("clock enable output not following");
  AST_CS_SETTLE: assert property (!init_done |-> chip_select_out == 4'hf)
    else $error("select output low before run");
  AST_DONE_TIME: assert property (disable iff (rst) $fell(rst) |->
    ##HOLD !init_done ##1 init_done)
    else $error("settle length wrong");
  AST_FB_RUN: assert property (disable iff (rst)
    feedback_clock_out_oe && $past(feedback_clock_out_oe) |->
    feedback_clock_out != $past(feedback_clock_out))
    else $error("feedback clock stalled");
  // main scenarios reached
  COV_RELEASE: cover property ($fell(rst));
  COV_FLOAT: cover property (init_done && !addr_cmd_out_oe);
  COV_SOFT: cover property (rst && $past(init_done));
endmodule : rcd_seq_checker

// >>> rcd_ctrl_model.sv
// rcd_ctrl_model.sv: memory controller side driving selects and enables
// assumes the bench supplies requests and reset; passes them once in run
`timescale 1ns/1ps
module rcd_ctrl_model (
  // status
  input wire logic       rst,
  input wire logic       init_done,
  // bench requests
  input wire logic [3:0] cs_req,
  input wire logic [1:0] cke_req,
  // lines to the sequencer
  output logic [3:0]     chip_select_in,
  output logic [1:0]     clock_enable_in
);
  // selects high, enables low around release: no stray word access
  assign chip_select_in  = (rst || !init_done) ? 4'hf : cs_req;
  assign clock_enable_in = (rst || !init_done) ? 2'h0 : cke_req;
endmodule : rcd_ctrl_model

// >>> tb_rcd_reset_init_sequencer.sv
// tb_rcd_reset_init_sequencer.sv: self-checking bench of the sequencer
// assumes checker and controller model compiled before it
`timescale 1ns/1ps
module tb_rcd_reset_init_sequencer;
  localparam int STAB = 20;
  localparam int ACT  = 5;
  logic        core_clk, rst, mode, par, init_done, cs_oe, odt_oe, ac_oe, pe, pe_oe, fb, fb_oe;
  logic [3:0]  cs_req, cs_in, cs_out, cke_out, odt_out;
  logic [1:0]  cke_req, cke_in, odt_req;
  logic [21:0] ac_req, ac_out;
  int          bad_count, num_checks, cyc;
  rcd_reset_init_sequencer #(.AC_W(22), .ACT_CYCLES(ACT), .STAB_CYCLES(STAB)) dut_u (
    .core_clk(core_clk), .rst(rst), .four_select_mode(mode), .chip_select_in(cs_in),
    .clock_enable_in(cke_in), .termination_ctrl_in(odt_req), .addr_cmd_in(ac_req),
    .parity_in(par), .chip_select_out(cs_out), .chip_select_out_oe(cs_oe),
    .clock_enable_out(cke_out), .termination_ctrl_out(odt_out),
    .termination_ctrl_out_oe(odt_oe), .addr_cmd_out(ac_out), .addr_cmd_out_oe(ac_oe),
    .parity_error_out(pe), .parity_error_out_oe(pe_oe), .feedback_clock_out(fb),
    .feedback_clock_out_oe(fb_oe), .init_done(init_done));
  rcd_ctrl_model ctrl_u (.rst(rst), .init_done(init_done), .cs_req(cs_req),
    .cke_req(cke_req), .chip_select_in(cs_in), .clock_enable_in(cke_in));
  ////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // two-select strap ignores the upper pair; a word access is not forwarded
  function automatic logic [3:0] exp_cs(input logic [3:0] c, input logic m);
    if (m ? c[1:0] == 2'h0 : c == 4'h0) return 4'hf;
    return m ? {2'h3, c[1:0]} : c;
  endfunction : exp_cs
  ////////////////////////////////////////////////////////////////
  // reset held for hold cycles, released off the edge, settle timed
  task automatic boot(input logic m, input int hold);
    int n;
    @(negedge core_clk);
    rst = 1'b1;
    mode = m;
    repeat (hold) begin
      @(negedge core_clk);
      cs_req = 4'($urandom);
      check(32'(cke_out), 0);
      check(32'({cs_oe, odt_oe, ac_oe, fb_oe, pe_oe}), 0);
    end
    rst = 1'b0;
    #1;
    check(32'({odt_out, odt_oe}), 1);
    check(32'(cs_out), 32'hf);
    n = 0;
    while (init_done !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
      check(32'({cs_out, cke_out}), 32'hf0);
    end
    check(32'(n), 32'(STAB - ACT + 1));
  endtask : boot
  // random pass-through, compared one edge after each drive
  task automatic traffic(input int cnt);
    logic [3:0]  pc;
    logic [1:0]  pk, po;
    logic [21:0] pa;
    for (int i = 0; i <= cnt; i++) begin
      @(negedge core_clk);
      if (i > 0) begin
        check(32'(cs_out), 32'(exp_cs(pc, mode)));
        check(32'({cke_out, odt_out}), 32'({pk, pk, po, po}));
        check(32'(ac_out), 32'(pa));
        // no float word written here: everything but the error flag drives
        check(32'({cs_oe, odt_oe, ac_oe, fb_oe, pe_oe}), 32'h1e);
      end
      pc = 4'($urandom);
      if (exp_cs(pc, mode) == 4'hf && pc != 4'hf) pc[0] = 1'b1;
      pk = 2'($urandom);
      po = 2'($urandom);
      pa = 22'($urandom);
      cs_req = pc;
      cke_req = pk;
      odt_req = po;
      ac_req = pa;
      par = 1'($urandom);
    end
  endtask : traffic
  // optional word 0 write of the float enable, then a deselected stretch
  task automatic float_test(input logic wr, input logic exp_oe);
    @(negedge core_clk);
    cs_req = wr ? 4'h0 : 4'hf;
    ac_req = 22'h10;
    @(negedge core_clk);
    cs_req = 4'hf;
    check(32'(cs_out), 32'hf);
    repeat (3) @(negedge core_clk);
    check(32'(ac_oe), 32'(exp_oe));
  endtask : float_test
  ////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    num_checks = 0;
    cyc = 0;
    rst = 1'b0;
    mode = 1'b0;
    par = 1'b0;
    cs_req = 4'hf;
    cke_req = 2'h0;
    odt_req = 2'h3;
    ac_req = 22'h0;
    // a real rising reset edge after time zero, so no flop misses it
    #1;
    rst = 1'b1;
    void'($urandom(32'h8bc22c91));
    boot(1'b0, 8);
    traffic(300);
    float_test(1'b1, 1'b0);
    boot(1'b1, 5);
    float_test(1'b0, 1'b1);
    traffic(300);
    boot(1'b0, 10000);
    traffic(50);
    tally_and_finish();
  end
endmodule : tb_rcd_reset_init_sequencer

bind rcd_reset_init_sequencer rcd_seq_checker #(.ACT_CYCLES(ACT_CYCLES),
  .STAB_CYCLES(STAB_CYCLES)) chk_u (.core_clk(core_clk), .rst(rst), .init_done(init_done),
  .clock_enable_in(clock_enable_in), .termination_ctrl_in(termination_ctrl_in),
  .chip_select_out(chip_select_out), .chip_select_out_oe(chip_select_out_oe),
  .clock_enable_out(clock_enable_out), .termination_ctrl_out(termination_ctrl_out),
  .termination_ctrl_out_oe(termination_ctrl_out_oe), .addr_cmd_out_oe(addr_cmd_out_oe),
  .parity_error_out_oe(parity_error_out_oe), .feedback_clock_out(feedback_clock_out),
  .feedback_clock_out_oe(feedback_clock_out_oe));
